// File: logic/lcd_defines.svh
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH
// ==========================
// Address limits and write masks
`define LCD_LAST_COL   7'h65
`define LCD_LAST_PAGE  4'h7
`define LCD_IND_PAGE   4'h8
`define LCD_IND_MASK   8'h01
`define LCD_FULL_MASK  8'hff
// ==========================
// Reset values and last serial bit count
`define LCD_RST_VOLUME 5'h10
`define LCD_RST_PWR    3'h0
`define LCD_RST_RATIO  3'h0
`define LCD_RST_BIAS6  1'b1
`define LCD_SER_LAST   3'h7
// ==========================
// Command encodings
`define LCD_OP_DISP    8'b1010_111?
`define LCD_OP_REV     8'b1010_011?
`define LCD_OP_ALLON   8'b1010_010?
`define LCD_OP_BIAS    8'b1010_001?
`define LCD_OP_SEGDIR  8'b1010_000?
`define LCD_OP_PAGE    8'b1011_????
`define LCD_OP_COLHI   8'b0001_0???
`define LCD_OP_COLLO   8'b0000_????
`define LCD_OP_START   8'b01??_????
`define LCD_OP_COMDIR  8'b1100_????
`define LCD_OP_PWR     8'b0010_1???
`define LCD_OP_RATIO   8'b0010_0???
`define LCD_OP_RMW     8'he0
`define LCD_OP_END     8'hee
`define LCD_OP_VOLUME  8'h81
`define LCD_OP_RESET   8'he2
`endif

// File: logic/lcd_pkg.sv
package lcd_pkg;
   // ==========================
   // Host bus selection
   typedef enum logic [1:0] {
      lcd_mode_8080,
      lcd_mode_6800,
      lcd_mode_serial
   } lcd_mode_type;
   // One received byte
   typedef struct packed {
      logic       valid;
      logic       is_data;
      logic       is_read;
      logic [7:0] data;
   } lcd_byte_type;
   // Display RAM access request
   typedef struct packed {
      logic       we;
      logic       re;
      logic [3:0] page;
      logic [6:0] col;
      logic [7:0] data;
      logic [7:0] mask;
   } lcd_ram_type;
   // Controller state set by commands
   typedef struct packed {
      logic       display_on;
      logic       reverse;
      logic       all_on;
      logic       power_save;
      logic       seg_rev;
      logic       com_rev;
      logic       rmw;
      logic       bias_sixth;
      logic [2:0] power_ctrl;
      logic [2:0] ratio;
      logic [4:0] volume;
      logic [3:0] page;
      logic [6:0] column;
      logic [5:0] start_line;
   } lcd_ctrl_type;
endpackage : lcd_pkg

// File: logic/lcd_par_front.sv
`timescale 1ns/1ps
module lcd_par_front (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   // Parallel host pins
   input  wire lcd_pkg::lcd_mode_type mode_in,
   input  wire logic              cds_in,
   input  wire logic              rd_e_in,
   input  wire logic              wr_rw_in,
   input  wire logic [7:0]        data_in,
   // Received byte
   output lcd_pkg::lcd_byte_type  byte_out
);
   typedef struct packed {
      logic                  armed;
      logic                  rd_q;
      logic                  wr_q;
      lcd_pkg::lcd_byte_type byte_v;
   } lcd_front_state_type;
   lcd_front_state_type st_q, st_d;
   // ==========================
   // Strobe edge detection
   always_comb begin
      st_d        = st_q;
      st_d.armed  = 1'b1;
      st_d.rd_q   = rd_e_in;
      st_d.wr_q   = wr_rw_in;
      st_d.byte_v = '0;
      if (st_q.armed && mode_in == lcd_pkg::lcd_mode_8080) begin
         if (!st_q.rd_q && rd_e_in) begin
            st_d.byte_v = '{1'b1, cds_in, 1'b1, data_in};
         end else if (!st_q.wr_q && wr_rw_in) begin
            st_d.byte_v = '{1'b1, cds_in, 1'b0, data_in};
         end
      end
      if (st_q.armed && mode_in == lcd_pkg::lcd_mode_6800) begin
         if (st_q.rd_q && !rd_e_in) begin
            st_d.byte_v = '{1'b1, cds_in, wr_rw_in, data_in};
         end
      end
   end
   // State register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign byte_out = st_q.byte_v;
endmodule : lcd_par_front

// File: logic/lcd_ser_shift.sv
`timescale 1ns/1ps
`include "lcd_defines.svh"
module lcd_ser_shift (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // Control
   input  wire logic             enable_in,
   input  wire logic             clear_in,
   // Serial pins
   input  wire logic             cds_in,
   input  wire logic             sclk_in,
   input  wire logic             sdata_in,
   // Received byte
   output lcd_pkg::lcd_byte_type byte_out
);
   typedef struct packed {
      logic                  armed;
      logic                  sclk_q;
      logic [6:0]            shift;
      logic [2:0]            count;
      lcd_pkg::lcd_byte_type byte_v;
   } lcd_ser_state_type;
   lcd_ser_state_type st_q, st_d;
   // ==========================
   // Shift on rising serial clock
   always_comb begin
      st_d        = st_q;
      st_d.armed  = 1'b1;
      st_d.sclk_q = sclk_in;
      st_d.byte_v = '0;
      if (st_q.armed && !st_q.sclk_q && sclk_in) begin
         if (st_q.count == `LCD_SER_LAST) begin
            st_d.byte_v = '{1'b1, cds_in, 1'b0, {st_q.shift, sdata_in}};
            st_d.count  = 3'h0;
         end else begin
            st_d.shift = {st_q.shift[5:0], sdata_in};
            st_d.count = 3'(st_q.count + 3'h1);
         end
      end
      if (clear_in || !enable_in) begin
         st_d.shift = 7'h00;
         st_d.count = 3'h0;
      end
   end
   // State register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign byte_out = st_q.byte_v;
   // ==========================
   // Checks
   property p_ser_clear;
      @(posedge clock_in) disable iff (rst_in)
      clear_in |=> st_q.count == 3'h0 && st_q.shift == 7'h00;
   endproperty
   a_ser_clear: assert property (p_ser_clear) else $error("shift not cleared");
   property p_ser_msb;
      @(posedge clock_in) disable iff (rst_in)
      st_q.byte_v.valid |-> st_q.byte_v.data[0] == $past(sdata_in);
   endproperty
   a_ser_msb: assert property (p_ser_msb) else $error("last bit not LSB");
endmodule : lcd_ser_shift

// File: logic/lcd_cmd_top.sv
// What this block does
// - Init by low pin or reset command
// - Init clears serial shifter and counter
// - Init enters power saver, all-on set
// - Init zeroes addresses, normal polarity, directions
// - Init clears power control and ratio
// - Init loads volume with 10000 binary
// - Init selects 1/6 bias, no test
// - Init leaves display RAM untouched
// - 8080 mode: low strobe pulses access
// - 6800 mode: R/W direction, E pulse
// - Serial bytes arrive MSB first
// - Command 1010111x switches display on/off
// - Display off plus all-on means saver
// - Command 1010011x selects display polarity
// - All-on forces points, overrides polarity
// - Command 1011xxxx loads page 0..8
// - Page 8 writes only bit 0
// - Page advances after last column
// - Column increments, wraps after 65H
// - Two commands load column halves
// - Command 01xxxxxx loads start line
// - Data write stores byte at address
`timescale 1ns/1ps
`include "lcd_defines.svh"
module lcd_cmd_top (
   // Clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   // Host selection and init
   input  wire lcd_pkg::lcd_mode_type bus_mode_in,
   input  wire logic                  init_pin_n_in,
   // Parallel host bus
   input  wire logic                  cmd_data_select_in,
   input  wire logic                  rd_e_in,
   input  wire logic                  wr_rw_in,
   input  wire logic [7:0]            data_in,
   // Serial host link
   input  wire logic                  serial_clk_in,
   input  wire logic                  serial_data_in,
   // Display RAM side
   input  wire logic                  pixel_data_in,
   output lcd_pkg::lcd_ram_type       ram_out,
   output logic                       pixel_on_out,
   // Controller state
   output lcd_pkg::lcd_ctrl_type      ctrl_out
);
   typedef struct packed {
      lcd_pkg::lcd_ctrl_type ctrl;
      lcd_pkg::lcd_ram_type  ram;
      logic                  pixel_on;
      logic                  vol_pend;
      logic [6:0]            rmw_col;
   } lcd_top_state_type;

   // ==========================
   // Reset state
   localparam lcd_top_state_type ST_RST = '{
      ctrl: '{
         display_on: 1'b0,
         reverse:    1'b0,
         all_on:     1'b1,
         power_save: 1'b1,
         seg_rev:    1'b0,
         com_rev:    1'b0,
         rmw:        1'b0,
         bias_sixth: `LCD_RST_BIAS6,
         power_ctrl: `LCD_RST_PWR,
         ratio:      `LCD_RST_RATIO,
         volume:     `LCD_RST_VOLUME,
         page:       4'h0,
         column:     7'h00,
         start_line: 6'h00
      },
      ram:      '0,
      pixel_on: 1'b0,
      vol_pend: 1'b0,
      rmw_col:  7'h00
   };

   lcd_top_state_type     st_q, st_d;
   lcd_pkg::lcd_byte_type par_byte;
   lcd_pkg::lcd_byte_type ser_byte;
   lcd_pkg::lcd_byte_type in_byte;
   logic                  cmd_ok;
   logic                  init_now;
   logic                  ser_en;
   logic                  at_last_col;
   logic [6:0]            adv_col;
   logic [3:0]            adv_page;

   // ==========================
   // Host front ends
   lcd_par_front u_par (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .mode_in  (bus_mode_in),
      .cds_in   (cmd_data_select_in),
      .rd_e_in  (rd_e_in),
      .wr_rw_in (wr_rw_in),
      .data_in  (data_in),
      .byte_out (par_byte)
   );

   lcd_ser_shift u_ser (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .enable_in (ser_en),
      .clear_in  (init_now),
      .cds_in    (cmd_data_select_in),
      .sclk_in   (serial_clk_in),
      .sdata_in  (serial_data_in),
      .byte_out  (ser_byte)
   );

   // Byte source and init detection
   assign ser_en   = bus_mode_in == lcd_pkg::lcd_mode_serial;
   assign in_byte  = ser_en ? ser_byte : par_byte;
   assign cmd_ok   = in_byte.valid && !in_byte.is_data && !in_byte.is_read;
   assign init_now = !init_pin_n_in
                   || (cmd_ok && !st_q.vol_pend
                       && in_byte.data == `LCD_OP_RESET);

   // Address advance after an access
   assign at_last_col = st_q.ctrl.column == `LCD_LAST_COL;
   assign adv_col     = at_last_col ? 7'h00 : 7'(st_q.ctrl.column + 7'h01);
   always_comb begin
      adv_page = st_q.ctrl.page;
      if (at_last_col) begin
         if (st_q.ctrl.page >= `LCD_LAST_PAGE) begin
            adv_page = 4'h0;
         end else begin
            adv_page = 4'(st_q.ctrl.page + 4'h1);
         end
      end
   end

   // ==========================
   // Command and data decode
   always_comb begin
      st_d        = st_q;
      st_d.ram.we = 1'b0;
      st_d.ram.re = 1'b0;
      if (in_byte.valid && in_byte.is_data) begin
         st_d.ram.page = st_q.ctrl.page;
         st_d.ram.col  = st_q.ctrl.column;
         if (!in_byte.is_read) begin
            st_d.ram.we   = 1'b1;
            st_d.ram.data = in_byte.data;
            st_d.ram.mask = (st_q.ctrl.page == `LCD_IND_PAGE)
                          ? `LCD_IND_MASK : `LCD_FULL_MASK;
         end else begin
            st_d.ram.re = 1'b1;
         end
         // Reads hold the column while read-modify-write is on
         if (!in_byte.is_read || !st_q.ctrl.rmw) begin
            st_d.ctrl.column = adv_col;
            st_d.ctrl.page   = adv_page;
         end
      end else if (cmd_ok && st_q.vol_pend) begin
         st_d.ctrl.volume = in_byte.data[4:0];
         st_d.vol_pend    = 1'b0;
      end else if (cmd_ok) begin
         unique casez (in_byte.data)
            `LCD_OP_DISP: begin
               st_d.ctrl.display_on = in_byte.data[0];
            end
            `LCD_OP_REV: begin
               st_d.ctrl.reverse = in_byte.data[0];
            end
            `LCD_OP_ALLON: begin
               st_d.ctrl.all_on = in_byte.data[0];
            end
            `LCD_OP_BIAS: begin
               st_d.ctrl.bias_sixth = in_byte.data[0];
            end
            `LCD_OP_SEGDIR: begin
               st_d.ctrl.seg_rev = in_byte.data[0];
            end
            `LCD_OP_PAGE: begin
               if (in_byte.data[3:0] <= `LCD_IND_PAGE) begin
                  st_d.ctrl.page = in_byte.data[3:0];
               end
            end
            `LCD_OP_COLHI: begin
               st_d.ctrl.column[6:4] = in_byte.data[2:0];
            end
            `LCD_OP_COLLO: begin
               st_d.ctrl.column[3:0] = in_byte.data[3:0];
            end
            `LCD_OP_START: begin
               st_d.ctrl.start_line = in_byte.data[5:0];
            end
            `LCD_OP_COMDIR: begin
               st_d.ctrl.com_rev = in_byte.data[3];
            end
            `LCD_OP_PWR: begin
               st_d.ctrl.power_ctrl = in_byte.data[2:0];
            end
            `LCD_OP_RATIO: begin
               st_d.ctrl.ratio = in_byte.data[2:0];
            end
            `LCD_OP_RMW: begin
               st_d.ctrl.rmw = 1'b1;
               st_d.rmw_col  = st_q.ctrl.column;
            end
            `LCD_OP_END: begin
               st_d.ctrl.rmw    = 1'b0;
               st_d.ctrl.column = st_q.rmw_col;
            end
            `LCD_OP_VOLUME: begin
               st_d.vol_pend = 1'b1;
            end
            default: begin
               st_d.vol_pend = st_q.vol_pend;
            end
         endcase
      end
      // Saver follows display off with all points on
      st_d.ctrl.power_save = !st_d.ctrl.display_on && st_d.ctrl.all_on;
      // Point drive: all-on beats polarity, saver grounds it
      st_d.pixel_on = !st_q.ctrl.power_save
                    && (st_q.ctrl.all_on
                        || (pixel_data_in ^ st_q.ctrl.reverse));
      if (init_now) begin
         st_d = ST_RST;
      end
   end

   // State register
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs
   assign ram_out      = st_q.ram;
   assign pixel_on_out = st_q.pixel_on;
   assign ctrl_out     = st_q.ctrl;

   // ==========================
   // Checks
   property p_init_saver;
      @(posedge clock_in) disable iff (rst_in)
      !init_pin_n_in |=> ctrl_out.power_save && !ctrl_out.display_on
                         && ctrl_out.all_on && !pixel_on_out;
   endproperty
   a_init_saver: assert property (p_init_saver) else $error("no saver on init");

   property p_init_addr;
      @(posedge clock_in) disable iff (rst_in)
      init_now |=> ctrl_out.page == 4'h0 && ctrl_out.column == 7'h00
                   && ctrl_out.start_line == 6'h00 && !ctrl_out.reverse
                   && !ctrl_out.rmw && !ctrl_out.seg_rev;
   endproperty
   a_init_addr: assert property (p_init_addr) else $error("addresses not reset");

   property p_init_power;
      @(posedge clock_in) disable iff (rst_in)
      init_now |=> ctrl_out.power_ctrl == 3'h0 && ctrl_out.ratio == 3'h0
                   && ctrl_out.volume == 5'h10 && ctrl_out.bias_sixth;
   endproperty
   a_init_power: assert property (p_init_power) else $error("power regs not reset");

   property p_init_noram;
      @(posedge clock_in) disable iff (rst_in)
      init_now |=> !ram_out.we;
   endproperty
   a_init_noram: assert property (p_init_noram) else $error("RAM written on init");

   property p_disp;
      @(posedge clock_in) disable iff (rst_in)
      cmd_ok && !init_now && !st_q.vol_pend && in_byte.data[7:1] == 7'h57
      |=> ctrl_out.display_on == $past(in_byte.data[0]);
   endproperty
   a_disp: assert property (p_disp) else $error("display on/off not taken");

   property p_saver;
      @(posedge clock_in) disable iff (rst_in)
      cmd_ok && !init_now && !st_q.vol_pend && (in_byte.data == 8'hae && ctrl_out.all_on
         || in_byte.data == 8'ha5 && !ctrl_out.display_on) |=> ctrl_out.power_save;
   endproperty
   a_saver: assert property (p_saver) else $error("saver state wrong");

   property p_pixel;
      @(posedge clock_in) disable iff (rst_in)
      !init_now && !ctrl_out.power_save |=> pixel_on_out
         == ($past(ctrl_out.all_on) || ($past(pixel_data_in) ^ $past(ctrl_out.reverse)));
   endproperty
   a_pixel: assert property (p_pixel) else $error("point drive wrong");

   property p_page_set;
      @(posedge clock_in) disable iff (rst_in)
      cmd_ok && !init_now && !st_q.vol_pend && in_byte.data[7:4] == 4'hb
      && in_byte.data[3:0] <= 4'h8 |=> ctrl_out.page == $past(in_byte.data[3:0]);
   endproperty
   a_page_set: assert property (p_page_set) else $error("page not loaded");

   property p_ind_mask;
      @(posedge clock_in) disable iff (rst_in)
      in_byte.valid && in_byte.is_data && !in_byte.is_read && !init_now
      && ctrl_out.page == 4'h8 |=> ram_out.we && ram_out.mask == 8'h01;
   endproperty
   a_ind_mask: assert property (p_ind_mask) else $error("indicator mask wrong");

   property p_wrap;
      @(posedge clock_in) disable iff (rst_in)
      in_byte.valid && in_byte.is_data && !in_byte.is_read && !init_now
      && ctrl_out.column == 7'h65 && ctrl_out.page == 4'h7
      |=> ctrl_out.column == 7'h00 && ctrl_out.page == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address wrap wrong");

   property p_write;
      @(posedge clock_in) disable iff (rst_in)
      in_byte.valid && in_byte.is_data && !in_byte.is_read && !init_now
      |=> ram_out.we && ram_out.data == $past(in_byte.data)
          && ram_out.col == $past(ctrl_out.column);
   endproperty
   a_write: assert property (p_write) else $error("data write lost");

   property p_start;
      @(posedge clock_in) disable iff (rst_in)
      cmd_ok && !init_now && !st_q.vol_pend && in_byte.data[7:6] == 2'h1
      |=> ctrl_out.start_line == $past(in_byte.data[5:0]);
   endproperty
   a_start: assert property (p_start) else $error("start line not loaded");

endmodule : lcd_cmd_top

// File: test/lcd_host_model.sv
`timescale 1ns/1ps
module lcd_host_model (
   // Clock
   input  wire logic             clock_in,
   // Host pins
   output lcd_pkg::lcd_mode_type mode_out,
   output logic                  init_pin_n_out,
   output logic                  cds_out,
   output logic                  rd_e_out,
   output logic                  wr_rw_out,
   output logic [7:0]            data_out,
   output logic                  sclk_out,
   output logic                  sdata_out
);
   // ==========================
   // Power-on levels, init pin low
   initial begin
      mode_out       = lcd_pkg::lcd_mode_8080;
      init_pin_n_out = 1'b0;
      cds_out        = 1'b0;
      rd_e_out       = 1'b1;
      wr_rw_out      = 1'b1;
      data_out       = 8'h00;
      sclk_out       = 1'b0;
      sdata_out      = 1'b0;
   end
   // Step just past a rising edge
   task automatic tick;
      @(posedge clock_in);
      #1;
   endtask : tick
   // Select bus, strobes parked idle
   task automatic set_mode(input lcd_pkg::lcd_mode_type m);
      mode_out  = m;
      rd_e_out  = (m != lcd_pkg::lcd_mode_6800);
      wr_rw_out = rd_e_out;
   endtask : set_mode
   // Init pin low for n cycles
   task automatic init_pulse(input int n);
      init_pin_n_out = 1'b0;
      repeat (n) tick;
      init_pin_n_out = 1'b1;
   endtask : init_pulse
   // Serial: top n bits, clock idles low
   task automatic shift(input logic sel, input logic [7:0] b, input int n);
      cds_out = sel;
      for (int i = 7; i > 7 - n; i--) begin
         tick;
         sdata_out = b[i];
         sclk_out  = 1'b0;
         tick;
         sclk_out  = 1'b1;
      end
      tick;
      sclk_out  = 1'b0;
      sdata_out = ~sdata_out;
   endtask : shift
   // One byte; a read when rd is set and the bus is parallel
   task automatic xfer(input logic sel, input logic [7:0] b, input logic rd);
      if (mode_out == lcd_pkg::lcd_mode_serial) begin
         shift(sel, b, 8);
      end else begin
         tick;
         cds_out  = sel;
         data_out = b;
         if (mode_out == lcd_pkg::lcd_mode_8080) begin
            rd_e_out  = !rd;
            wr_rw_out = rd;
            tick;
            rd_e_out  = 1'b1;
            wr_rw_out = 1'b1;
         end else begin
            wr_rw_out = rd;
            rd_e_out  = 1'b1;
            tick;
            rd_e_out  = 1'b0;
         end
         tick;
         data_out = ~b;
      end
   endtask : xfer
endmodule : lcd_host_model

// File: test/lcd_cmd_top_tb.sv
`timescale 1ns/1ps
module lcd_cmd_top_tb;
   // ==========================
   // Signals and scoreboard
   logic                  clock_in;
   logic                  rst_in;
   logic                  pixel_data_in;
   lcd_pkg::lcd_mode_type bus_mode;
   logic                  init_n;
   logic                  cds;
   logic                  rd_e;
   logic                  wr_rw;
   logic [7:0]            data;
   logic                  sclk;
   logic                  sdata;
   lcd_pkg::lcd_ram_type  ram_out;
   logic                  pixel_on_out;
   lcd_pkg::lcd_ctrl_type ctrl_out;
   lcd_pkg::lcd_ctrl_type exp_st;
   lcd_pkg::lcd_ram_type  exp_q[$];
   logic [6:0]            saved_col;
   logic                  vol_pend;
   int                    errors;
   int                    check_count;
   int                    seed;
   logic [11:0]           seq[] = '{12'h0af, 12'h0a7, 12'h0a5, 12'h0a4, 12'h0a6, 12'h0a3,
      12'h0a2, 12'h0a1, 12'h0a0, 12'h0b8, 12'h0bf, 12'h07f, 12'h040, 12'h0c8, 12'h0c0,
      12'h02f, 12'h023, 12'h081, 12'h01f, 12'h018, 12'h0ff, 12'h0ae, 12'h0a5, 12'h0af,
      12'h0e2, 12'h0b7, 12'h016, 12'h005, 12'h1a1, 12'h1a2, 12'h0b8, 12'h016, 12'h005,
      12'h13c, 12'h0b6, 12'h016, 12'h005, 12'h177, 12'h0b2, 12'h013, 12'h004, 12'h0e0,
      12'h200, 12'h200, 12'h155, 12'h156, 12'h0ee, 12'h200, 12'h0a4};
   // ==========================
   // Host model and design
   lcd_host_model host (
      .clock_in       (clock_in),
      .mode_out       (bus_mode),
      .init_pin_n_out (init_n),
      .cds_out        (cds),
      .rd_e_out       (rd_e),
      .wr_rw_out      (wr_rw),
      .data_out       (data),
      .sclk_out       (sclk),
      .sdata_out      (sdata)
   );
   lcd_cmd_top dut (
      .clock_in           (clock_in),
      .rst_in             (rst_in),
      .bus_mode_in        (bus_mode),
      .init_pin_n_in      (init_n),
      .cmd_data_select_in (cds),
      .rd_e_in            (rd_e),
      .wr_rw_in           (wr_rw),
      .data_in            (data),
      .serial_clk_in      (sclk),
      .serial_data_in     (sdata),
      .pixel_data_in      (pixel_data_in),
      .ram_out            (ram_out),
      .pixel_on_out       (pixel_on_out),
      .ctrl_out           (ctrl_out)
   );
   // 100 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // ==========================
   // Compare and verdict
   task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
      check_count++;
      if (seen !== want) begin
         errors++;
         $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   // ==========================
   // Expected controller state
   task automatic exp_reset;
      exp_st            = '0;
      exp_st.all_on     = 1'b1;
      exp_st.power_save = 1'b1;
      exp_st.bias_sixth = 1'b1;
      exp_st.volume     = 5'h10;
      vol_pend          = 1'b0;
   endtask : exp_reset
   task automatic exp_cmd(input logic [7:0] b);
      if (vol_pend) begin
         exp_st.volume = b[4:0];
         vol_pend      = 1'b0;
      end else if (b == 8'he2) begin
         exp_reset;
      end else if (b == 8'h81) begin
         vol_pend = 1'b1;
      end else if (b == 8'he0) begin
         exp_st.rmw = 1'b1;
         saved_col  = exp_st.column;
      end else if (b == 8'hee) begin
         exp_st.rmw    = 1'b0;
         exp_st.column = saved_col;
      end else if (b[7:1] == 7'h57) begin
         exp_st.display_on = b[0];
      end else if (b[7:1] == 7'h53) begin
         exp_st.reverse = b[0];
      end else if (b[7:1] == 7'h52) begin
         exp_st.all_on = b[0];
      end else if (b[7:1] == 7'h51) begin
         exp_st.bias_sixth = b[0];
      end else if (b[7:1] == 7'h50) begin
         exp_st.seg_rev = b[0];
      end else if (b[7:4] == 4'hb) begin
         if (b[3:0] <= 4'h8) exp_st.page = b[3:0];
      end else if (b[7:6] == 2'b01) begin
         exp_st.start_line = b[5:0];
      end else if (b[7:4] == 4'hc) begin
         exp_st.com_rev = b[3];
      end else if (b[7:3] == 5'h05) begin
         exp_st.power_ctrl = b[2:0];
      end else if (b[7:3] == 5'h04) begin
         exp_st.ratio = b[2:0];
      end else if (b[7:3] == 5'h02) begin
         exp_st.column[6:4] = b[2:0];
      end else if (b[7:4] == 4'h0) begin
         exp_st.column[3:0] = b[3:0];
      end
      exp_st.power_save = !exp_st.display_on && exp_st.all_on;
   endtask : exp_cmd
   // Note one RAM access, then advance the address unless it is a read during read-modify-write
   task automatic exp_data(input logic [7:0] b, input logic rd);
      lcd_pkg::lcd_ram_type r;
      r      = '0;
      r.we   = !rd;
      r.re   = rd;
      r.page = exp_st.page;
      r.col  = exp_st.column;
      r.data = b;
      r.mask = (exp_st.page == 4'h8) ? 8'h01 : 8'hff;
      exp_q.push_back(r);
      if (!(rd && exp_st.rmw)) begin
         if (exp_st.column == 7'h65) begin
            exp_st.column = 7'h00;
            exp_st.page   = (exp_st.page >= 4'h7) ? 4'h0 : exp_st.page + 4'h1;
         end else begin
            exp_st.column = exp_st.column + 7'h01;
         end
      end
   endtask : exp_data
   // ==========================
   // Stimulus helpers
   task automatic settle;
      logic [31:0] r;
      r             = $random(seed);
      pixel_data_in = r[0];
      repeat (4) host.tick;
      check(ctrl_out, exp_st, "controller state");
      check(pixel_on_out, !exp_st.power_save && (exp_st.all_on || (r[0] ^ exp_st.reverse)),
            "point drive");
   endtask : settle
   task automatic cmd(input logic [7:0] b);
      host.xfer(1'b0, b, 1'b0);
      exp_cmd(b);
      settle;
   endtask : cmd
   task automatic dat(input logic [7:0] b, input logic rd);
      if (!(rd && bus_mode == lcd_pkg::lcd_mode_serial)) begin
         exp_data(b, rd);
         host.xfer(1'b1, b, rd);
      end
   endtask : dat
   task automatic run_mode(input lcd_pkg::lcd_mode_type m);
      logic [31:0] r;
      rst_in = 1'b1;
      host.set_mode(m);
      repeat (2) host.tick;
      rst_in = 1'b0;
      exp_reset;
      settle;
      foreach (seq[i]) begin
         if (seq[i][11:8] == 4'h0) cmd(seq[i][7:0]);
         else dat(seq[i][7:0], seq[i][9]);
      end
      settle;
      repeat (40) begin
         r = $random(seed);
         if (r[7:5] == 3'b000 || r[7:4] == 4'he) r[7:6] = 2'b01;
         if (r[9]) dat(r[7:0], 1'b0);
         else cmd(r[7:0]);
      end
      cmd(8'haf);
      host.init_pulse(2);
      exp_reset;
      settle;
      host.shift(1'b0, 8'hff, 3);
      host.init_pulse(1);
      exp_reset;
      cmd(8'haf);
      $display("mode %0d done", m);
   endtask : run_mode
   // ==========================
   // Each RAM access pulse takes the oldest note
   always @(posedge clock_in) begin
      if (!rst_in && (ram_out.we === 1'b1 || ram_out.re === 1'b1)) begin
         if (exp_q.size() == 0) begin
            check(1'b1, 1'b0, "access with no note");
         end else if (ram_out.re === 1'b1) begin
            check({ram_out.we, ram_out.re, ram_out.page, ram_out.col},
                  {exp_q[0].we, exp_q[0].re, exp_q[0].page, exp_q[0].col}, "read");
            void'(exp_q.pop_front());
         end else begin
            check(ram_out, exp_q.pop_front(), "write");
         end
      end
   end
   // Main sequence
   initial begin
      seed          = 32'h9b9b9f2a;
      errors        = 0;
      check_count   = 0;
      rst_in        = 1'b1;
      pixel_data_in = 1'b0;
      repeat (6) @(posedge clock_in);
      #1;
      host.init_pulse(1);
      for (int m = 0; m < 3; m++) run_mode(lcd_pkg::lcd_mode_type'(m[1:0]));
      wrap_up;
   end
   // Watchdog
   initial begin
      #500000;
      errors++;
      wrap_up;
   end
endmodule : lcd_cmd_top_tb
